// ===== design/mlr_pkg.sv
// package for the move, logic, rotate and skip execution unit
// Behaviour
// - memory to accumulator, flags untouched
// - immediate byte to accumulator, flags untouched
// - accumulator to memory, flags untouched
// - no-operation only advances program counter
// - OR into accumulator, zero flag only
// - OR into memory, zero flag only
// - return pops counter, two cycles, no flags
// - return pops counter and loads immediate
// - interrupt return pops counter, sets master enable
// - rotate memory left, bit 7 to 0
// - rotate left into accumulator, memory kept
// - rotate left through carry, nine-bit ring
// - rotate right, bit 0 to 7
// - rotate right through carry, carry to 7
// - subtract with carry into accumulator, four flags
// - subtract with carry into memory, same flags
// - decrement memory, skip when zero, two cycles on skip
// - decrement into accumulator, skip when zero
// - skip discards prefetch, inserts dummy cycle
package mlr_pkg;

  // operations this unit executes
  typedef enum logic [4:0] {
    MLR_NOP, MLR_MOV_A_M, MLR_MOV_A_X, MLR_MOV_M_A,
    MLR_OR_A_M, MLR_OR_A_X, MLR_ORM,
    MLR_RET, MLR_RET_A_X, MLR_RETI,
    MLR_RL, MLR_RLA, MLR_RLC, MLR_RLCA,
    MLR_RR, MLR_RRA, MLR_RRC, MLR_RRCA,
    MLR_SBC, MLR_SBCM, MLR_SDZ, MLR_SDZA
  } mlr_op_t;

  // one instruction as handed over by the sequencer
  typedef struct packed {
    mlr_op_t op;
    logic [7:0] imm;       // immediate field
    logic [7:0] mem_rd;    // byte read from the addressed location
  } mlr_instr_t;

  // side effects towards memory, stack and sequencer
  typedef struct packed {
    logic mem_we;          // write mem_wdata to the addressed location
    logic [7:0] mem_wdata;
    logic pc_inc;          // advance program counter by one
    logic pc_pop;          // load program counter from the stack
    logic discard;         // drop the prefetched instruction
  } mlr_effect_t;

  // register map, byte addresses
  localparam logic [3:0] MLR_ACC_OFS = 4'h0;
  localparam logic [3:0] MLR_FLAG_OFS = 4'h4;
  localparam logic [3:0] MLR_CTRL_OFS = 4'h8;
  localparam logic [3:0] MLR_STAT_OFS = 4'hC;

  // flag register fields, and the enable bit of the control register
  localparam int MLR_C_BIT = 0;
  localparam int MLR_AC_BIT = 1;
  localparam int MLR_Z_BIT = 2;
  localparam int MLR_OV_BIT = 3;
  localparam int MLR_MIE_BIT = 0;

  // reset values
  localparam logic [7:0] MLR_ACC_RST = 8'h00;
  localparam logic [3:0] MLR_FLAG_RST = 4'h0;
  localparam logic MLR_MIE_RST = 1'b0;

  // cycle counts per instruction class
  localparam int MLR_RET_CYCLES = 2;
  localparam int MLR_SKIP_CYCLES = 2;

endpackage : mlr_pkg

// ===== design/mlr_exec.sv
// execution unit for moves, OR, rotates, subtract with carry, returns and skips
//
// The register addresses and the Avalon-MM register port were decided locally.
`timescale 1ns/100ps
module mlr_exec
  import mlr_pkg::*;
#(
  parameter int DATA_W = 8
) (
  input wire logic ref_clk_in,              // system clock, 250 MHz
  input wire logic rst_in,                  // asynchronous reset, active high
  input wire logic instr_valid_in,          // sequencer offers an instruction
  output logic instr_ready_out,             // unit can take an instruction
  input wire mlr_instr_t instr_in,          // instruction and operand byte
  output mlr_effect_t effect_out,           // registered side effects, one cycle
  output logic [7:0] acc_out,               // accumulator
  output logic [3:0] flags_out,             // {ov, z, ac, c}
  output logic master_interrupt_enable_out, // global interrupt enable
  input wire logic [3:0] avs_address,       // byte address
  input wire logic avs_read,                // avalon read
  input wire logic avs_write,               // avalon write
  input wire logic [31:0] avs_writedata,    // avalon write data
  input wire logic [3:0] avs_byteenable,    // avalon byte enables
  output logic [31:0] avs_readdata,         // avalon read data
  output logic avs_waitrequest              // avalon wait request
);

  // the datapath is byte wide by construction; wider words would need new flag taps
  if (DATA_W != 8) begin : g_width_check
    $error("mlr_exec supports only DATA_W = 8");
  end

  // the sequencer below holds exactly one refused cycle after a return or a taken skip
  if (MLR_RET_CYCLES != 2 || MLR_SKIP_CYCLES != 2) begin : g_cycle_check
    $error("mlr_exec serves only two-cycle returns and skips");
  end

  typedef enum logic [1:0] {
    ST_RUN,
    ST_RET2,
    ST_DUMMY
  } mlr_state_t;

  mlr_state_t state_q;
  logic [7:0] acc_q;
  logic [3:0] flags_q;
  logic mie_q;
  mlr_effect_t effect_q;
  logic bus_ack_q;
  logic [31:0] rdata_q;
  logic [4:0] last_op_q;

  logic take;
  logic [7:0] m;
  logic cin;
  logic acc_we;
  logic [7:0] acc_d;
  logic [3:0] flags_d;
  logic flags_we;
  logic mie_set;
  mlr_effect_t effect_d;
  logic skip;
  logic [8:0] diff;
  logic [4:0] low;
  logic bus_wr;
  logic bus_rd;
  logic [7:0] or_m;

  // zero test shared by OR, subtract and skip paths
  function automatic logic is_zero(input logic [7:0] v);
    is_zero = (v == 8'h00);
  endfunction : is_zero

  // updates the zero flag inside a flag vector
  function automatic logic [3:0] with_zero(input logic [3:0] f, input logic [7:0] v);
    logic [3:0] r;
    r = f;
    r[MLR_Z_BIT] = is_zero(v);
    with_zero = r;
  endfunction : with_zero

  // rotate one place left, bit 7 wraps into bit 0
  function automatic logic [7:0] rot_left(input logic [7:0] v);
    rot_left = {v[6:0], v[7]};
  endfunction : rot_left

  // rotate one place right, bit 0 wraps into bit 7
  function automatic logic [7:0] rot_right(input logic [7:0] v);
    rot_right = {v[0], v[7:1]};
  endfunction : rot_right

  // left through carry: old carry enters bit 0, bit 7 leaves as new carry
  function automatic logic [7:0] rot_left_c(input logic [7:0] v, input logic c);
    rot_left_c = {v[6:0], c};
  endfunction : rot_left_c

  // right through carry: old carry enters bit 7, bit 0 leaves as new carry
  function automatic logic [7:0] rot_right_c(input logic [7:0] v, input logic c);
    rot_right_c = {c, v[7:1]};
  endfunction : rot_right_c

  // decrement wraps 00 to FF, which is not zero and so never skips
  function automatic logic [7:0] dec_byte(input logic [7:0] v);
    dec_byte = v - 8'h01;
  endfunction : dec_byte

  // an instruction is taken only in the run state, never in a second cycle
  assign take = instr_valid_in && (state_q == ST_RUN);
  assign instr_ready_out = (state_q == ST_RUN);
  assign m = instr_in.mem_rd;
  assign cin = flags_q[MLR_C_BIT];

  // subtract with carry: acc + ~m + c, nibble carry from bit 3
  assign diff = {1'b0, acc_q} + {1'b0, ~m} + {8'h00, cin};
  assign low = {1'b0, acc_q[3:0]} + {1'b0, ~m[3:0]} + {4'h0, cin};

  // one OR term shared by the accumulator and memory forms
  assign or_m = acc_q | m;

  // decode one instruction into accumulator, flag and memory effects
  always_comb begin
    acc_we = 1'b0;
    acc_d = acc_q;
    flags_we = 1'b0;
    flags_d = flags_q;
    mie_set = 1'b0;
    skip = 1'b0;
    effect_d = '0;
    effect_d.pc_inc = take;
    if (take) begin
      case (instr_in.op)
        MLR_NOP: begin
          effect_d.pc_inc = 1'b1;
        end
        MLR_MOV_A_M: begin
          acc_we = 1'b1;
          acc_d = m;
        end
        MLR_MOV_A_X: begin
          acc_we = 1'b1;
          acc_d = instr_in.imm;
        end
        MLR_MOV_M_A: begin
          effect_d.mem_we = 1'b1;
          effect_d.mem_wdata = acc_q;
        end
        MLR_OR_A_M: begin
          acc_we = 1'b1;
          acc_d = or_m;
          flags_we = 1'b1;
          flags_d = with_zero(flags_q, or_m);
        end
        MLR_OR_A_X: begin
          acc_we = 1'b1;
          acc_d = acc_q | instr_in.imm;
          flags_we = 1'b1;
          flags_d = with_zero(flags_q, acc_q | instr_in.imm);
        end
        MLR_ORM: begin
          effect_d.mem_we = 1'b1;
          effect_d.mem_wdata = or_m;
          flags_we = 1'b1;
          flags_d = with_zero(flags_q, or_m);
        end
        MLR_RET: begin
          effect_d.pc_inc = 1'b0;
          effect_d.pc_pop = 1'b1;
        end
        MLR_RET_A_X: begin
          effect_d.pc_inc = 1'b0;
          effect_d.pc_pop = 1'b1;
          acc_we = 1'b1;
          acc_d = instr_in.imm;
        end
        MLR_RETI: begin
          effect_d.pc_inc = 1'b0;
          effect_d.pc_pop = 1'b1;
          mie_set = 1'b1;
        end
        MLR_RL: begin
          effect_d.mem_we = 1'b1;
          effect_d.mem_wdata = rot_left(m);
        end
        MLR_RLA: begin
          acc_we = 1'b1;
          acc_d = rot_left(m);
        end
        MLR_RLC, MLR_RLCA: begin
          if (instr_in.op == MLR_RLC) begin
            effect_d.mem_we = 1'b1;
            effect_d.mem_wdata = rot_left_c(m, cin);
          end else begin
            acc_we = 1'b1;
            acc_d = rot_left_c(m, cin);
          end
          flags_we = 1'b1;
          flags_d[MLR_C_BIT] = m[7];
        end
        MLR_RR: begin
          effect_d.mem_we = 1'b1;
          effect_d.mem_wdata = rot_right(m);
        end
        MLR_RRA: begin
          acc_we = 1'b1;
          acc_d = rot_right(m);
        end
        MLR_RRC, MLR_RRCA: begin
          if (instr_in.op == MLR_RRC) begin
            effect_d.mem_we = 1'b1;
            effect_d.mem_wdata = rot_right_c(m, cin);
          end else begin
            acc_we = 1'b1;
            acc_d = rot_right_c(m, cin);
          end
          flags_we = 1'b1;
          flags_d[MLR_C_BIT] = m[0];
        end
        MLR_SBC, MLR_SBCM: begin
          if (instr_in.op == MLR_SBC) begin
            acc_we = 1'b1;
            acc_d = diff[7:0];
          end else begin
            effect_d.mem_we = 1'b1;
            effect_d.mem_wdata = diff[7:0];
          end
          flags_we = 1'b1;
          flags_d = with_zero(flags_q, diff[7:0]);
          flags_d[MLR_C_BIT] = diff[8];
          flags_d[MLR_AC_BIT] = low[4];
          flags_d[MLR_OV_BIT] = (acc_q[7] == ~m[7]) && (diff[7] != acc_q[7]);
        end
        MLR_SDZ: begin
          effect_d.mem_we = 1'b1;
          effect_d.mem_wdata = dec_byte(m);
          skip = is_zero(dec_byte(m));
        end
        // decrement to accumulator, skip on zero
        MLR_SDZA: begin
          acc_we = 1'b1;
          acc_d = dec_byte(m);
          skip = is_zero(dec_byte(m));
        end
        default: begin
          effect_d.pc_inc = 1'b1;
        end
      endcase
      effect_d.discard = skip;
    end
  end

  // sequencing: returns and taken skips occupy a second cycle
  // ready drops in that cycle, so the sequencer cannot push a word into the gap
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= ST_RUN;
    end else begin
      case (state_q)
        ST_RUN: begin
          if (take && (instr_in.op == MLR_RET || instr_in.op == MLR_RET_A_X ||
                       instr_in.op == MLR_RETI)) begin
            state_q <= ST_RET2;
          end else if (take && skip) begin
            state_q <= ST_DUMMY;
          end
        end
        ST_RET2: state_q <= ST_RUN;
        ST_DUMMY: state_q <= ST_RUN;
        default: state_q <= ST_RUN;
      endcase
    end
  end

  // avalon decode; one wait state, answer on the second cycle
  // a fixed wait state lets read data come from a flop with no read-data mux path
  assign avs_waitrequest = (avs_read || avs_write) && !bus_ack_q;
  assign bus_wr = avs_write && bus_ack_q && avs_byteenable[0];
  assign bus_rd = avs_read && !bus_ack_q;

  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      bus_ack_q <= 1'b0;
    end else begin
      bus_ack_q <= (avs_read || avs_write) && !bus_ack_q;
    end
  end

  // accumulator: instruction wins over a same-cycle bus write
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      acc_q <= MLR_ACC_RST;
    end else if (acc_we) begin
      acc_q <= acc_d;
    end else if (bus_wr && avs_address == MLR_ACC_OFS) begin
      acc_q <= avs_writedata[7:0];
    end
  end

  // flags: only listed flags move per instruction
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      flags_q <= MLR_FLAG_RST;
    end else if (flags_we) begin
      flags_q <= flags_d;
    end else if (bus_wr && avs_address == MLR_FLAG_OFS) begin
      flags_q <= avs_writedata[3:0];
    end
  end

  // master interrupt enable: the interrupt return sets it, set wins over a bus clear
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      mie_q <= MLR_MIE_RST;
    end else if (mie_set) begin
      mie_q <= 1'b1;
    end else if (bus_wr && avs_address == MLR_CTRL_OFS) begin
      mie_q <= avs_writedata[MLR_MIE_BIT];
    end
  end

  // side effects are registered so memory sees clean one-cycle strobes
  // the cost is one cycle of latency between the take and the memory write
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      effect_q <= '0;
      last_op_q <= 5'h00;
    end else begin
      effect_q <= effect_d;
      if (take) begin
        last_op_q <= instr_in.op;
      end
    end
  end

  // read data captured in the wait cycle, valid when waitrequest drops
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_q <= 32'h0000_0000;
    end else if (bus_rd) begin
      // status packs the last op taken over the sequencer state, for tracing
      case (avs_address)
        MLR_ACC_OFS: rdata_q <= {24'h00_0000, acc_q};
        MLR_FLAG_OFS: rdata_q <= {28'h000_0000, flags_q};
        MLR_CTRL_OFS: rdata_q <= {31'h0000_0000, mie_q};
        MLR_STAT_OFS: rdata_q <= {24'h00_0000, last_op_q, 1'b0, state_q};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign avs_readdata = rdata_q;
  assign effect_out = effect_q;
  assign acc_out = acc_q;
  assign flags_out = flags_q;
  assign master_interrupt_enable_out = mie_q;

endmodule : mlr_exec

// ===== tb/mlr_checker.sv
// concurrent checks on the execution unit ports
`timescale 1ns/100ps
module mlr_checker
  import mlr_pkg::*;
(
  input wire logic ref_clk_in, // clock
  input wire logic rst_in, // reset
  input wire logic instr_valid_in, // offer
  input wire logic instr_ready_out, // accept
  input wire mlr_instr_t instr_in, // instruction
  input wire mlr_effect_t effect_out, // effects
  input wire logic [7:0] acc_out, // accumulator
  input wire logic [3:0] flags_out, // flags
  input wire logic master_interrupt_enable_out // enable
);
  logic tk;
  mlr_op_t op;
  logic [7:0] rl;
  // taken instruction and its operand rotated left
  assign tk = instr_valid_in && instr_ready_out;
  assign op = instr_in.op;
  assign rl = {instr_in.mem_rd[6:0], instr_in.mem_rd[7]};
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  // one refused cycle after a pop or a skip
  sequence s_gap;
    !instr_ready_out ##1 instr_ready_out;
  endsequence
  sequence s_pop;
    effect_out.pc_pop ##0 s_gap;
  endsequence
  sequence s_drop;
    effect_out.discard ##0 s_gap;
  endsequence
  property p_nop;
    tk && op == MLR_NOP |=> effect_out.pc_inc && !effect_out.mem_we && $stable(acc_out);
  endproperty
  a_nop: assert property (p_nop) else $error("nop changed state");
  property p_movx;
    tk && op == MLR_MOV_A_X |=> acc_out == $past(instr_in.imm) && $stable(flags_out);
  endproperty
  a_movx: assert property (p_movx) else $error("immediate move wrong");
  property p_movm;
    tk && op == MLR_MOV_M_A |=> effect_out.mem_we && effect_out.mem_wdata == $past(acc_out);
  endproperty
  a_movm: assert property (p_movm) else $error("store wrong");
  property p_or;
    tk && op == MLR_OR_A_X |=> acc_out == ($past(acc_out) | $past(instr_in.imm))
      && flags_out[MLR_Z_BIT] == (acc_out == 8'h00);
  endproperty
  a_or: assert property (p_or) else $error("or wrong");
  property p_ret;
    tk && op == MLR_RET |=> s_pop;
  endproperty
  a_ret: assert property (p_ret) else $error("return timing wrong");
  property p_reti;
    tk && op == MLR_RETI |=> master_interrupt_enable_out && effect_out.pc_pop;
  endproperty
  a_reti: assert property (p_reti) else $error("enable not set");
  property p_rl;
    tk && op == MLR_RL |=> effect_out.mem_we && effect_out.mem_wdata == $past(rl);
  endproperty
  a_rl: assert property (p_rl) else $error("rotate wrong");
  property p_skip;
    tk && op inside {MLR_SDZ, MLR_SDZA} && instr_in.mem_rd == 8'h01 |=> s_drop;
  endproperty
  a_skip: assert property (p_skip) else $error("skip wrong");
endmodule : mlr_checker

bind mlr_exec mlr_checker u_mlr_checker (.ref_clk_in, .rst_in, .instr_valid_in,
  .instr_ready_out, .instr_in, .effect_out, .acc_out, .flags_out,
  .master_interrupt_enable_out);

// ===== tb/mlr_mem_model.sv
// data memory byte that feeds the operand
`timescale 1ns/100ps
module mlr_mem_model
  import mlr_pkg::*;
(
  input wire logic ref_clk_in, // clock
  input wire mlr_effect_t effect_in, // unit side effects
  input wire logic load_in, // bench preload
  input wire logic [7:0] load_data_in, // preload byte
  output logic [7:0] rd_out // addressed byte
);
  logic [7:0] mem_q;
  // a pending write is forwarded, else back to back ops read stale data
  assign rd_out = load_in ? load_data_in : effect_in.mem_we ? effect_in.mem_wdata : mem_q;
  // keep the last written byte
  always_ff @(posedge ref_clk_in) begin
    if (load_in) mem_q <= load_data_in;
    else if (effect_in.mem_we) mem_q <= effect_in.mem_wdata;
  end
endmodule : mlr_mem_model

// ===== tb/tb_top.sv
// self-checking bench for the execution unit
`timescale 1ns/100ps
module tb_top
  import mlr_pkg::*;
;
  logic ref_clk_in = 1'h0;
  logic rst_in = 1'h1;
  logic instr_valid_in = 1'h0;
  logic ld = 1'h0;
  logic tk = 1'h0;
  logic [7:0] imm_q = 8'h00;
  logic [7:0] ld_v = 8'h00;
  mlr_op_t op_q = MLR_NOP;
  logic [3:0] avs_address = 4'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [7:0] m_acc = 8'h00;
  logic [7:0] m_mem = 8'h00;
  logic [3:0] m_flg = 4'h0;
  logic m_mie = 1'h0;
  logic [7:0] rd, acc_out;
  logic [3:0] flags_out;
  logic [31:0] avs_readdata;
  logic instr_ready_out, mie, avs_waitrequest;
  mlr_instr_t instr_in;
  mlr_effect_t effect_out;
  logic [24:0] rq[$];
  logic [31:0] bq[$];
  int fail_count = 0;
  int total_checks = 0;
  int seed = 50460;
  mlr_exec u_mlr_exec (.ref_clk_in, .rst_in, .instr_valid_in, .instr_ready_out, .instr_in,
    .effect_out, .acc_out, .flags_out, .master_interrupt_enable_out(mie), .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest);
  mlr_mem_model u_mlr_mem_model (.ref_clk_in, .effect_in(effect_out), .load_in(ld),
    .load_data_in(ld_v), .rd_out(rd));
  assign instr_in = {op_q, imm_q, rd};
  // 250 MHz clock
  always #2 ref_clk_in = ~ref_clk_in;
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // one bus cycle, held until waitrequest is seen low
  task automatic bus(logic w, logic [3:0] a, logic [31:0] d, logic [3:0] be);
    logic wt;
    int n;
    n = 0;
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    do begin
      @(negedge ref_clk_in);
      wt = avs_waitrequest;
      @(posedge ref_clk_in);
      n++;
    end while (wt && n < 20);
    if (wt !== 1'h0) begin
      fail_count++;
      end_of_test();
    end
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    @(posedge ref_clk_in);
  endtask : bus
  // predict one instruction, then offer it until taken
  task automatic run(mlr_op_t op, logic [7:0] x, logic l, logic [7:0] lv);
    logic [7:0] m, r;
    logic [8:0] s;
    logic [4:0] h;
    logic we, rdy, pop;
    int n;
    m = l ? lv : m_mem;
    r = m;
    n = 0;
    case (op)
      MLR_MOV_A_M: m_acc = m;
      MLR_MOV_A_X, MLR_RET_A_X: m_acc = x;
      MLR_MOV_M_A: r = m_acc;
      MLR_OR_A_M, MLR_OR_A_X: m_acc = m_acc | (op == MLR_OR_A_M ? m : x);
      MLR_ORM: r = m_acc | m;
      MLR_RL, MLR_RLA: r = {m[6:0], m[7]};
      MLR_RLC, MLR_RLCA: {m_flg[0], r} = {m, m_flg[0]};
      MLR_RR, MLR_RRA: r = {m[0], m[7:1]};
      MLR_RRC, MLR_RRCA: {r, m_flg[0]} = {m_flg[0], m};
      MLR_SBC, MLR_SBCM: begin
        s = {1'h0, m_acc} + {1'h0, ~m} + m_flg[0];
        h = {1'h0, m_acc[3:0]} + {1'h0, ~m[3:0]} + m_flg[0];
        r = s[7:0];
        m_flg = {(m_acc[7] == ~m[7]) && (r[7] != m_acc[7]), r == 8'h00, h[4], s[8]};
      end
      MLR_SDZ, MLR_SDZA: r = m - 8'h01;
      MLR_RETI: m_mie = 1'h1;
      default: ;
    endcase
    we = op inside {MLR_MOV_M_A, MLR_ORM, MLR_RL, MLR_RLC, MLR_RR, MLR_RRC, MLR_SBCM, MLR_SDZ};
    if (op inside {MLR_RLA, MLR_RLCA, MLR_RRA, MLR_RRCA, MLR_SBC, MLR_SDZA}) m_acc = r;
    if (op inside {MLR_OR_A_M, MLR_OR_A_X}) m_flg[2] = m_acc == 8'h00;
    if (op == MLR_ORM) m_flg[2] = r == 8'h00;
    m_mem = we ? r : m;
    pop = op inside {MLR_RET, MLR_RET_A_X, MLR_RETI};
    rq.push_back({m_acc, m_flg, m_mie, we, we ? r : 8'h00, !pop, pop,
      op inside {MLR_SDZ, MLR_SDZA} && r == 8'h00});
    op_q <= op;
    imm_q <= x;
    ld <= l;
    ld_v <= lv;
    instr_valid_in <= 1'h1;
    do begin
      @(negedge ref_clk_in);
      rdy = instr_ready_out;
      @(posedge ref_clk_in);
      n++;
    end while (!rdy && n < 20);
    if (rdy !== 1'h1) begin
      fail_count++;
      end_of_test();
    end
  endtask : run
  task automatic stop();
    instr_valid_in <= 1'h0;
    ld <= 1'h0;
    @(posedge ref_clk_in);
  endtask : stop
  // results are compared against the oldest note, one cycle after the take
  always @(negedge ref_clk_in) begin
    if (tk) chk("result", rq.pop_front(), {acc_out, flags_out, mie,
      effect_out.mem_we, effect_out.mem_we ? effect_out.mem_wdata : 8'h00, effect_out.pc_inc,
      effect_out.pc_pop, effect_out.discard});
    if (avs_read && !avs_waitrequest) chk("readdata", bq.pop_front(), avs_readdata);
    tk = instr_valid_in && instr_ready_out;
  end
  initial begin
    logic [31:0] v;
    int k;
    repeat (16) @(posedge ref_clk_in);
    rst_in <= 1'h0;
    @(posedge ref_clk_in);
    // reset values of all four registers, then the unmapped place 0xD
    for (int i = 0; i < 5; i++) begin
      bq.push_back(32'h0);
      bus(1'h0, (i < 4) ? 4'(i * 4) : 4'hD, 32'h0, 4'hF);
    end
    v = $random(seed);
    bus(1'h1, MLR_CTRL_OFS, 32'h1, 4'hE);
    bus(1'h1, MLR_ACC_OFS, v, 4'hF);
    bus(1'h1, MLR_FLAG_OFS, v >> 8, 4'hF);
    m_acc = v[7:0];
    m_flg = v[11:8];
    bq.push_back({24'h0, m_acc});
    bus(1'h0, MLR_ACC_OFS, 32'h0, 4'hF);
    bq.push_back(32'h0);
    bus(1'h0, MLR_CTRL_OFS, 32'h0, 4'hF);
    $display("test registers done");
    // skips and returns back to back
    run(MLR_SDZ, 8'h00, 1'h1, 8'h01);
    run(MLR_SDZA, 8'h00, 1'h1, 8'h01);
    run(MLR_RET, 8'h00, 1'h0, 8'h00);
    run(MLR_RETI, 8'h00, 1'h0, 8'h00);
    run(MLR_RET_A_X, v[23:16], 1'h0, 8'h00);
    run(MLR_NOP, 8'h00, 1'h0, 8'h00);
    stop();
    bq.push_back(32'h1);
    bus(1'h0, MLR_CTRL_OFS, 32'h0, 4'hF);
    bus(1'h1, MLR_CTRL_OFS, 32'h0, 4'hF);
    m_mie = 1'h0;
    $display("test skip and return done");
    // every operation twice in order, then random ones
    for (int i = 0; i < 400; i++) begin
      v = $random(seed);
      k = (i < 44) ? i % 22 : v[31:27] % 22;
      run(mlr_op_t'(5'(k)), v[23:16], v[8], v[9] ? v[7:0] : {6'h0, v[1:0]});
    end
    stop();
    repeat (4) @(posedge ref_clk_in);
    // status shows the last op taken and the sequencer back in run
    bq.push_back({24'h0, 5'(k), 3'h0});
    bus(1'h0, MLR_STAT_OFS, 32'h0, 4'hF);
    chk("pending", 32'h0, rq.size() + bq.size());
    $display("test random done");
    end_of_test();
  end
endmodule : tb_top
